// *** verilog/sppe_top.sv ***
// register bank of physical and error management registers, apb slave
//
// The register addresses and the APB register port were chosen for this implementation.
`include "sppe_defines.svh"
`default_nettype none
module sppe_top #(
    parameter int NPORT = 8
) (
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_N,
    input  wire logic                 SELF_RST,
    input  wire logic [NPORT-1:0]     PORT_RST,
    input  wire logic [NPORT-1:0]     PORT_PWRDN,
    input  wire logic [NPORT-1:0]     PORT_FOUR_LANE,
    input  wire logic                 I2C_LOAD_VALID,
    input  wire logic [23:0]          I2C_TIMEOUT,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [15:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic                      PREADY,
    output logic [31:0]               PRDATA,
    output logic                      PSLVERR,
    input  wire logic [NPORT*5-1:0]   ACKID_STATUS,
    input  wire logic [NPORT*5-1:0]   BUF_STATUS,
    input  wire logic [NPORT-1:0]     PKT_SENT,
    input  wire logic [NPORT-1:0]     ACK_SEEN,
    input  wire logic [NPORT-1:0]     RSP_VALID,
    input  wire logic [NPORT*8-1:0]   RSP_DATA,
    input  wire logic [NPORT-1:0]     LINK_ERR,
    input  wire logic [NPORT-1:0]     BUS_ERR,
    input  wire logic [NPORT-1:0]     MAINT_PKT,
    input  wire logic [NPORT*8-1:0]   MAINT_HOP,
    input  wire logic [NPORT-1:0]     MAINT_BAD,
    output logic [NPORT-1:0]          SYM_VALID,
    output logic [NPORT*19-1:0]       SYM_DATA,
    output logic [NPORT-1:0]          OUT_ERR,
    output logic [NPORT-1:0]          PORT_STOP,
    output logic [NPORT-1:0]          PORT_DROP,
    output logic [NPORT-1:0]          LT_REPORT
);
    import sppe_pkg::*;
    if (NPORT != 8) begin : g_nport_chk
        $error("sppe_top serves exactly eight ports");
    end
    // ============================================================================
    // bus decode
    logic       dev_rst_n;
    logic       acc;
    logic       wr;
    logic       phy_hit;
    logic       em_hit;
    logic       hdr_hit;
    logic [2:0] phy_idx;
    logic [2:0] em_idx;
    logic [4:0] phy_ofs;
    logic [5:0] em_ofs;
    assign dev_rst_n = RST_N && !SELF_RST;
    assign acc       = PSEL && PENABLE;
    assign wr        = acc && PWRITE;
    assign PREADY    = 1'b1;
    assign PSLVERR   = 1'b0;

    function automatic logic [16:0] blk_decode(input logic [15:0] a, input logic [15:0] base,
                                               input logic [15:0] step, input int n);
        logic [15:0] d;
        logic [16:0] r;
        r = 17'h0_0000;
        d = a - base;
        if (a >= base && d < 16'(n) * step) begin
            r[16] = 1'b1;
            r[15:0] = d;
        end
        return r;
    endfunction

    logic [16:0] pd;
    logic [16:0] ed;
    always_comb begin
        pd      = blk_decode({PADDR[15:2], 2'b00}, `SPPE_PHY_BASE, `SPPE_PHY_STEP, 8);
        ed      = blk_decode({PADDR[15:2], 2'b00}, `SPPE_EM_BASE, `SPPE_EM_STEP, 7);
        phy_hit = pd[16];
        phy_idx = pd[7:5];
        phy_ofs = pd[4:0];
        em_hit  = ed[16];
        em_idx  = 3'(ed[8:6] + 3'd1);
        em_ofs  = ed[5:0];
        hdr_hit = ({PADDR[15:2], 2'b00} == `SPPE_EM_HDR);
    end
    // ============================================================================
    // shared registers
    logic [23:0] timeout_q;
    logic [31:0] genctl_q;
    logic        pd_wr;
    assign pd_wr = phy_hit && PORT_PWRDN[phy_idx];
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            // boot load only under power-on reset, never in normal running
            timeout_q <= I2C_LOAD_VALID ? I2C_TIMEOUT : `SPPE_TIMEOUT_RST;
        end else if (SELF_RST) begin
            timeout_q <= `SPPE_TIMEOUT_RST;
        end else if (wr && phy_hit && !pd_wr && phy_ofs == `SPPE_OFS_TIMEOUT) begin
            timeout_q <= PWDATA[31:8];
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (!dev_rst_n) begin
            genctl_q <= 32'h0000_0000;
        end else if (wr && phy_hit && !pd_wr && phy_ofs == `SPPE_OFS_GENCTL) begin
            genctl_q <= {PWDATA[31:29], 29'h0000_0000};
        end
    end
    // ============================================================================
    // per-port registers
    logic [NPORT-1:0] prt_rst_n;
    logic [2:0]       lreq_q   [NPORT];
    logic [7:0]       lrsp_q   [NPORT];
    logic [31:0]      ctl_q    [NPORT];
    logic [1:0]       esflag_q [NPORT];
    logic [NPORT-1:0] errdet_q;
    logic [NPORT-1:0] erren_q;
    logic [NPORT-1:0] ltdet_q;
    logic [NPORT-1:0] lten_q;
    logic [7:0]       thr_q    [NPORT];
    logic [NPORT-1:0] busy;
    logic [7:0]       cnt      [NPORT];
    sppe_fail_act_t   act      [NPORT];

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : gp
            logic ph;
            logic eh;
            logic lreq_wr;
            logic lt_err;
            assign prt_rst_n[g] = dev_rst_n && !PORT_RST[g];
            assign ph = wr && phy_hit && phy_idx == 3'(g) && !PORT_PWRDN[g];
            assign eh = wr && em_hit && em_idx == 3'(g) && !PORT_PWRDN[g];
            assign lreq_wr = ph && phy_ofs == `SPPE_OFS_LREQ && !busy[g];
            assign lt_err = MAINT_PKT[g] && MAINT_HOP[g*8 +: 8] == 8'h00 && MAINT_BAD[g];
            always_ff @(posedge REF_CLK) begin
                if (!prt_rst_n[g]) begin
                    lreq_q[g]   <= 3'b000;
                    lrsp_q[g]   <= 8'h00;
                    ctl_q[g]    <= `SPPE_CTL_RST;
                    esflag_q[g] <= 2'b00;
                    erren_q[g]  <= 1'b0;
                    lten_q[g]   <= 1'b0;
                    thr_q[g]    <= 8'h00;
                end else begin
                    if (lreq_wr) lreq_q[g] <= PWDATA[2:0];
                    if (RSP_VALID[g]) lrsp_q[g] <= RSP_DATA[g*8 +: 8];
                    if (ph && phy_ofs == `SPPE_OFS_CTL) ctl_q[g] <= PWDATA;
                    if (ph && phy_ofs == `SPPE_OFS_ERRSTAT)
                        esflag_q[g] <= {PWDATA[`SPPE_ES_STOP_BIT], PWDATA[`SPPE_ES_DROP_BIT]};
                    if (eh && em_ofs == `SPPE_OFS_ERREN) erren_q[g] <= PWDATA[0];
                    if (eh && em_ofs == `SPPE_OFS_LTEN) lten_q[g] <= PWDATA[0];
                    if (eh && em_ofs == `SPPE_OFS_THRESH) thr_q[g] <= PWDATA[31:24];
                end
            end
            // detect bits: set wins over a clearing write
            always_ff @(posedge REF_CLK) begin
                if (!prt_rst_n[g]) begin
                    errdet_q[g] <= 1'b0;
                    ltdet_q[g]  <= 1'b0;
                end else begin
                    if (BUS_ERR[g] || lt_err) errdet_q[g] <= 1'b1;
                    else if (eh && em_ofs == `SPPE_OFS_ERRDET) errdet_q[g] <= PWDATA[0];
                    if (lt_err) ltdet_q[g] <= 1'b1;
                    else if (eh && em_ofs == `SPPE_OFS_LTDET) ltdet_q[g] <= PWDATA[0];
                end
            end
            always_ff @(posedge REF_CLK) begin
                if (!prt_rst_n[g]) LT_REPORT[g] <= 1'b0;
                else LT_REPORT[g] <= lt_err && lten_q[g];
            end
            sppe_port u_port (
                .clk          (REF_CLK),
                .rst_n        (prt_rst_n[g]),
                .timeout_val  (timeout_q),
                .lreq_wr      (lreq_wr),
                .lreq_cmd     (PWDATA[2:0]),
                .ackid_status (ACKID_STATUS[g*5 +: 5]),
                .buf_status   (BUF_STATUS[g*5 +: 5]),
                .pkt_sent     (PKT_SENT[g]),
                .ack_seen     (ACK_SEEN[g]),
                .rsp_valid    (RSP_VALID[g]),
                .err_event    (LINK_ERR[g] || (eh && em_ofs == `SPPE_OFS_ERRDET
                                               && PWDATA != 32'h0000_0000)),
                .err_enable   (erren_q[g]),
                .fail_thresh  (thr_q[g]),
                .stop_en      (esflag_q[g][1]),
                .drop_en      (esflag_q[g][0]),
                .sym_valid    (SYM_VALID[g]),
                .sym_data     (SYM_DATA[g*19 +: 19]),
                .lreq_busy    (busy[g]),
                .out_err      (OUT_ERR[g]),
                .err_count    (cnt[g]),
                .fail_act     (act[g])
            );
            // odd neighbour of a four-lane even port is held idle
            assign PORT_STOP[g] = (act[g] == SPPE_FAIL_STOP) ||
                                  ((g % 2 == 1) && PORT_FOUR_LANE[g - (g % 2)]);
            assign PORT_DROP[g] = (act[g] == SPPE_FAIL_DROP);
        end
    endgenerate
    // ============================================================================
    // read mux
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0000_0000;
        if (phy_hit) begin
            if (PORT_PWRDN[phy_idx] &&
                (phy_ofs == `SPPE_OFS_ERRSTAT || phy_ofs == `SPPE_OFS_CTL)) begin
                rd = `SPPE_PD_READ;
            end else begin
                case (phy_ofs)
                    `SPPE_OFS_TIMEOUT: rd = {timeout_q, 8'h00};
                    `SPPE_OFS_GENCTL:  rd = genctl_q;
                    `SPPE_OFS_LREQ:    rd = {29'h0000_0000, lreq_q[phy_idx]};
                    `SPPE_OFS_LRSP:    rd = {busy[phy_idx] ? 1'b0 : 1'b1, 23'h00_0000,
                                             lrsp_q[phy_idx]};
                    `SPPE_OFS_ERRSTAT: rd = {4'h0, esflag_q[phy_idx], 1'b0,
                                             act[phy_idx] != SPPE_FAIL_NONE, 7'h00,
                                             OUT_ERR[phy_idx], 16'h0000};
                    `SPPE_OFS_CTL:     rd = ctl_q[phy_idx];
                    default:           rd = 32'h0000_0000;
                endcase
            end
        end else if (em_hit && !PORT_PWRDN[em_idx]) begin
            case (em_ofs)
                `SPPE_OFS_ERRDET: rd = {31'h0000_0000, errdet_q[em_idx]};
                `SPPE_OFS_ERREN:  rd = {31'h0000_0000, erren_q[em_idx]};
                `SPPE_OFS_LTDET:  rd = {31'h0000_0000, ltdet_q[em_idx]};
                `SPPE_OFS_LTEN:   rd = {31'h0000_0000, lten_q[em_idx]};
                `SPPE_OFS_RATE:   rd = {24'h00_0000, cnt[em_idx]};
                `SPPE_OFS_THRESH: rd = {thr_q[em_idx], 24'h00_0000};
                default:          rd = 32'h0000_0000;
            endcase
        end else if (hdr_hit) begin
            rd = {16'h0000, `SPPE_EXTENDED_FEATURE_IDENTIFIER};
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) PRDATA <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE) PRDATA <= rd;
    end
    // ============================================================================
    // checks
    AST_PD_READ: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (PSEL && !PENABLE && !PWRITE && phy_hit && PORT_PWRDN[phy_idx]
         && phy_ofs == `SPPE_OFS_CTL) |=> PRDATA == `SPPE_PD_READ)
        else $error("powered-down control read not one");
    AST_UNMAPPED: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (PSEL && !PENABLE && !PWRITE && !phy_hit && !em_hit && !hdr_hit)
        |=> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_EM_PD: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (PSEL && !PENABLE && !PWRITE && em_hit && PORT_PWRDN[em_idx])
        |=> PRDATA == 32'h0000_0000)
        else $error("powered-down error read not zero");
    AST_NO_ERR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        acc |-> (PREADY && !PSLVERR))
        else $error("access answered with error");
    AST_BUSERR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        BUS_ERR[0] && !PORT_RST[0] && !SELF_RST |=> errdet_q[0])
        else $error("bus error not recorded");
    AST_TMO_RST: assert property (@(posedge REF_CLK)
        !RST_N && !I2C_LOAD_VALID |=> timeout_q == `SPPE_TIMEOUT_RST)
        else $error("timeout reset value wrong");
    AST_GEN_ALIAS: assert property (@(posedge REF_CLK) disable iff (!dev_rst_n)
        (wr && phy_hit && !pd_wr && phy_ofs == `SPPE_OFS_GENCTL)
        |=> genctl_q[31:29] == $past(PWDATA[31:29]))
        else $error("general control not shared");
    AST_LREQ_RB: assert property (@(posedge REF_CLK) disable iff (!prt_rst_n[0])
        (wr && phy_hit && phy_idx == 3'd0 && phy_ofs == `SPPE_OFS_LREQ && !busy[0]
         && !PORT_PWRDN[0]) |=> ##1 SYM_VALID[0] == 1'b0 && lreq_q[0] == $past(PWDATA[2:0], 2))
        else $error("link request readback wrong");
endmodule
`default_nettype wire

// *** verilog/sppe_defines.svh ***
// constants for the serial port physical and error register bank
// ============================================================================
// How it works
// - every register is one 32-bit word on an aligned address
// - powered-down port: physical registers read-only, reads undefined
// - hard reset and self-reset restore all; port reset restores that port
// - unmapped address reads zero, write completes without error
// - even port at four lanes makes odd neighbour contents meaningless
// - physical blocks start 0x0240 for port 8, step 0x20 to 0x0320
// - one shared link timeout, reset value is the maximum
// - expired link timeout puts that port into output-error state
// - general control bits are one copy aliased by every port
// - link request write sends a link-request symbol; read returns last write
// - symbol is status, ackid status, buffer status, link_req, command
// - command write ignored while own link request is outstanding
// - powered-down port error-status and control read 0x0000_0001
// - error block identifier 0x0007; port blocks 0x1280 to 0x1400 step 0x40
// - powered-down port error registers read-only and read zero
// - bus and transport errors report in bit 0 of port error detect
// - logical checks only cover hop-count-zero maintenance packets
// - enable bit decides lock of detect/capture and host reporting; here lten_q only gates LT_REPORT, nothing locks
// - failed threshold reaction chosen by stop-on-fail and drop enable
// - power-on reset only may load reset values over i2c
`ifndef SPPE_DEFINES_SVH
`define SPPE_DEFINES_SVH
// ============================================================================
// address map
`define SPPE_PHY_BASE      16'h0240
`define SPPE_PHY_STEP      16'h0020
`define SPPE_PHY_FIRST     4'h8
`define SPPE_EM_BASE       16'h1280
`define SPPE_EM_STEP       16'h0040
`define SPPE_EM_FIRST      4'h9
`define SPPE_EM_HDR        16'h1000
`define SPPE_EXTENDED_FEATURE_IDENTIFIER         16'h0007
// offsets within a physical block
`define SPPE_OFS_TIMEOUT   5'h00
`define SPPE_OFS_GENCTL    5'h04
`define SPPE_OFS_LREQ      5'h08
`define SPPE_OFS_LRSP      5'h0C
`define SPPE_OFS_ERRSTAT   5'h18
`define SPPE_OFS_CTL       5'h1C
// offsets within an error block
`define SPPE_OFS_ERRDET    6'h00
`define SPPE_OFS_ERREN     6'h04
`define SPPE_OFS_LTDET     6'h08
`define SPPE_OFS_LTEN      6'h0C
`define SPPE_OFS_RATE      6'h28
`define SPPE_OFS_THRESH    6'h2C
// reset values and fields
`define SPPE_TIMEOUT_RST   24'hFF_FFFF
`define SPPE_PD_READ       32'h0000_0001
`define SPPE_CTL_RST       32'h0000_0000
`define SPPE_ES_STOP_BIT   27
`define SPPE_ES_DROP_BIT   26
`define SPPE_ES_OUTERR_BIT 16
`define SPPE_ES_FAIL_BIT   24
`define SPPE_LT_LOCK_BIT   31
`endif

// *** verilog/sppe_pkg.sv ***
// types for the serial port physical and error register bank
`default_nettype none
package sppe_pkg;
    typedef enum logic [2:0] {
        SPPE_LR_IDLE = 3'b001,
        SPPE_LR_WAIT = 3'b010,
        SPPE_LR_DONE = 3'b100
    } sppe_lr_state_t;
    typedef enum logic [1:0] {
        SPPE_FAIL_NONE = 2'b00,
        SPPE_FAIL_DROP = 2'b01,
        SPPE_FAIL_STOP = 2'b10
    } sppe_fail_act_t;
endpackage
`default_nettype wire

// *** verilog/sppe_port.sv ***
// one port: link request engine, link timeout and error counting
`include "sppe_defines.svh"
`default_nettype none
module sppe_port (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [23:0]           timeout_val,
    input  wire logic                  lreq_wr,
    input  wire logic [2:0]            lreq_cmd,
    input  wire logic [4:0]            ackid_status,
    input  wire logic [4:0]            buf_status,
    input  wire logic                  pkt_sent,
    input  wire logic                  ack_seen,
    input  wire logic                  rsp_valid,
    input  wire logic                  err_event,
    input  wire logic                  err_enable,
    input  wire logic [7:0]            fail_thresh,
    input  wire logic                  stop_en,
    input  wire logic                  drop_en,
    output logic                       sym_valid,
    output logic [18:0]                sym_data,
    output logic                       lreq_busy,
    output logic                       out_err,
    output logic [7:0]                 err_count,
    output sppe_pkg::sppe_fail_act_t   fail_act
);
    import sppe_pkg::*;
    // ============================================================================
    // link request engine
    sppe_lr_state_t lr_q;
    logic [23:0]    tmo_q;
    logic           tmo_run_q;
    logic           expired;
    assign expired   = tmo_run_q && (tmo_q >= timeout_val);
    assign lreq_busy = (lr_q == SPPE_LR_WAIT);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lr_q      <= SPPE_LR_IDLE;
            sym_valid <= 1'b0;
            sym_data  <= 19'h0_0000;
        end else begin
            sym_valid <= 1'b0;
            case (lr_q)
                SPPE_LR_IDLE, SPPE_LR_DONE: begin
                    if (lreq_wr) begin
                        sym_valid <= 1'b1;
                        sym_data  <= {3'b000, ackid_status, buf_status, 3'b100, lreq_cmd};
                        lr_q      <= SPPE_LR_WAIT;
                    end
                end
                SPPE_LR_WAIT: begin
                    // writes here are dropped by the caller
                    if (rsp_valid || expired) begin
                        lr_q <= SPPE_LR_DONE;
                    end
                end
                default: lr_q <= SPPE_LR_IDLE;
            endcase
        end
    end
    // ============================================================================
    // link timeout counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmo_q     <= 24'h00_0000;
            tmo_run_q <= 1'b0;
        end else if (pkt_sent || (lreq_wr && !lreq_busy)) begin
            tmo_q     <= 24'h00_0000;
            tmo_run_q <= 1'b1;
        end else if (ack_seen || rsp_valid || expired) begin
            tmo_run_q <= 1'b0;
        end else if (tmo_run_q) begin
            tmo_q <= tmo_q + 24'h00_0001;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_err <= 1'b0;
        end else if (expired) begin
            out_err <= 1'b1;
        end else if (ack_seen || rsp_valid) begin
            out_err <= 1'b0;
        end
    end
    // ============================================================================
    // error rate counter and failed threshold reaction
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_count <= 8'h00;
        end else if (err_event && err_enable && err_count != 8'hFF) begin
            err_count <= err_count + 8'h01;
        end
    end
    always_comb begin
        fail_act = SPPE_FAIL_NONE;
        if (fail_thresh != 8'h00 && err_count >= fail_thresh) begin
            if (stop_en) fail_act = SPPE_FAIL_STOP;
            else if (drop_en) fail_act = SPPE_FAIL_DROP;
        end
    end
    AST_EXPIRE_ERR: assert property (@(posedge clk) disable iff (!rst_n)
        expired |=> out_err)
        else $error("timeout expiry did not raise output error");
    AST_SYM_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        sym_valid |=> !sym_valid)
        else $error("two link request symbols back to back");
    AST_SYM_CMD: assert property (@(posedge clk) disable iff (!rst_n)
        (lreq_wr && !lreq_busy) |=> (sym_valid && sym_data[2:0] == $past(lreq_cmd)))
        else $error("symbol command differs from write");
endmodule
`default_nettype wire

// *** verification/sppe_link_partner.sv ***
// link partner model: answers each link-request symbol after a set delay
`default_nettype none
module sppe_link_partner (
    input  wire logic        clk,
    input  wire logic [7:0]  sym_valid,
    input  wire logic [15:0] dly,
    output logic      [7:0]  rsp_valid,
    output logic      [63:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt [8] = '{default: 0};
    initial begin
        rsp_valid = '0;
        rsp_data  = '0;
    end
    // ============================================================
    // response engine
    always @(posedge clk) begin
        for (int p = 0; p < 8; p++) begin
            rsp_valid[p] <= 1'b0;
            // idle bytes toggle so a stale byte never passes for an answer
            rsp_data[p*8+:8] <= ~rsp_data[p*8+:8];
            if (sym_valid[p] === 1'b1) begin
                cnt[p] = int'(dly) + 1;
            end else if (cnt[p] > 1) begin
                cnt[p] = cnt[p] - 1;
            end else if (cnt[p] == 1) begin
                cnt[p] = 0;
                rsp_valid[p] <= 1'b1;
                rsp_data[p*8+:8] <= 8'hA0 | 8'(p);
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/sppe_top_tb.sv ***
// self-checking bench for the physical and error register bank
`default_nettype none
module sppe_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_n = 0, self_rst = 0, i2c_vld = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  port_rst = 0, pwrdn = 0, four = 0, pkt_sent = 0, bus_err = 0, zero8 = 0;
    logic [7:0]  sym_valid, out_err, stp, drp, ltr, rsp_valid;
    logic [15:0] paddr = 0, dly = 2;
    logic [23:0] i2c_to = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [39:0] ackid = 0, bufs = 0;
    logic [63:0] zero64 = 0, rsp_data;
    logic [151:0] sym_data;
    logic        pready, pslverr;
    logic [18:0] sym_d [8];
    int          sym_n [8] = '{default: 0};
    int          fails = 0, tests_run = 0;
    always #20 clk = ~clk;
    sppe_top #(.NPORT(8)) u_dut (.REF_CLK(clk), .RST_N(rst_n), .SELF_RST(self_rst),
        .PORT_RST(port_rst), .PORT_PWRDN(pwrdn), .PORT_FOUR_LANE(four),
        .I2C_LOAD_VALID(i2c_vld), .I2C_TIMEOUT(i2c_to), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .ACKID_STATUS(ackid), .BUF_STATUS(bufs), .PKT_SENT(pkt_sent),
        .ACK_SEEN(zero8), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .LINK_ERR(zero8),
        .BUS_ERR(bus_err), .MAINT_PKT(zero8), .MAINT_HOP(zero64), .MAINT_BAD(zero8),
        .SYM_VALID(sym_valid), .SYM_DATA(sym_data), .OUT_ERR(out_err), .PORT_STOP(stp),
        .PORT_DROP(drp), .LT_REPORT(ltr));
    sppe_link_partner u_partner (.clk(clk), .sym_valid(sym_valid), .dly(dly),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    // ============================================================
    // monitors and helpers
    always @(posedge clk) begin
        for (int p = 0; p < 8; p++) begin
            if (sym_valid[p] === 1'b1) begin
                sym_n[p]++;
                sym_d[p] = sym_data[p*19+:19];
            end
        end
    end
    function automatic logic [15:0] phy(input int p, input int o);
        return 16'(16'h0240 + 16'h0020 * (p - 8) + o);
    endfunction
    function automatic logic [18:0] sym_exp(input int i, input logic [2:0] c);
        return {3'b000, ackid[i*5+:5], bufs[i*5+:5], 3'b100, c};
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", {31'd0, pslverr}, 32'd0);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'd0);
        chk(nm, rd & m, exp);
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        wrap_up();
    end
    // ============================================================
    // main sequence
    initial begin
        int p, n;
        logic [2:0] c;
        logic [31:0] v;
        void'($urandom(32'h41d98bd0));
        {ackid, bufs, four} <= 88'({$urandom, $urandom, $urandom});
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdchk("timeout reset", phy(8, 0), 32'hFFFF_FFFF, 32'hFFFF_FF00);
        apb(1'b1, 16'h0100, 32'hFFFF_FFFF);
        rdchk("unmapped", 16'h0100, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk("ef header", 16'h1000, 32'hFFFF_FFFF, 32'h0000_0007);
        chk("four lane", {24'd0, stp}, {24'd0, (four << 1) & 8'hAA});
        chk("no drop", {24'd0, drp}, 32'd0);
        v = $urandom;
        apb(1'b1, phy(8, 4), v);
        rdchk("genctl alias", phy(15, 4), 32'hE000_0000, v & 32'hE000_0000);
        for (int i = 0; i < 6; i++) begin
            p = 8 + $urandom_range(7);
            c = 3'($urandom);
            dly <= (i % 2) ? 16'd40 : 16'd2;
            n = sym_n[p-8];
            apb(1'b1, phy(p, 8), {29'd0, c});
            if (i % 2) apb(1'b1, phy(p, 8), {29'd0, ~c});
            repeat (60) @(posedge clk); // wait past the 40-cycle partner delay; the write made while busy sends no symbol
            chk("sym count", 32'(sym_n[p-8]), 32'(n + 1));
            chk("sym data", {13'd0, sym_d[p-8]}, {13'd0, sym_exp(p - 8, c)});
            rdchk("lreq read", phy(p, 8), 32'h0000_0007, {29'd0, c});
            rdchk("lrsp", phy(p, 12), 32'h8000_00FF, {24'h80_0000, 8'hA0 | 8'(p - 8)});
        end
        pwrdn <= 8'h04;
        rdchk("pd errstat", phy(10, 24), 32'hFFFF_FFFF, 32'h0000_0001);
        rdchk("pd control", phy(10, 28), 32'hFFFF_FFFF, 32'h0000_0001);
        rdchk("pd errdet", 16'h12C0, 32'hFFFF_FFFF, 32'h0000_0000);
        n = sym_n[2];
        apb(1'b1, phy(10, 8), 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("pd lreq", 32'(sym_n[2]), 32'(n));
        pwrdn <= 8'h00;
        bus_err <= 8'h05;
        @(posedge clk);
        bus_err <= 8'h00;
        rdchk("errdet bit0", 16'h12C0, 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, 16'h12C4, 32'd1);
        apb(1'b1, 16'h12EC, 32'h0100_0000); // reserved bits left zero
        apb(1'b1, phy(10, 24), 32'h0400_0000);
        apb(1'b1, 16'h12C0, 32'd1);
        @(posedge clk);
        chk("drop act", {24'd0, drp}, 32'h0000_0004);
        apb(1'b1, phy(8, 0), 32'h0000_1000);
        pkt_sent <= 8'h02;
        @(posedge clk);
        pkt_sent <= 8'h00;
        for (n = 0; n < 100 && out_err[1] !== 1'b1; n++) @(posedge clk);
        chk("out_err time", {30'd0, n > 12, n < 40}, 32'd3);
        port_rst <= 8'h02;
        @(posedge clk);
        port_rst <= 8'h00;
        @(posedge clk);
        chk("port reset", {31'd0, out_err[1]}, 32'd0);
        self_rst <= 1'b1;
        @(posedge clk);
        self_rst <= 1'b0;
        rdchk("self reset", phy(12, 0), 32'hFFFF_FFFF, 32'hFFFF_FF00);
        i2c_to <= 24'($urandom);
        {rst_n, i2c_vld} <= 2'b01;
        @(posedge clk);
        {rst_n, i2c_vld} <= 2'b10;
        rdchk("i2c load", phy(9, 0), 32'hFFFF_FF00, {i2c_to, 8'h00});
        wrap_up();
    end
endmodule
`default_nettype wire
